// [shared/sfx_pkg.sv]
// Purpose: shared constants and types of the simd fp exception block
// Assumes: 128-bit operands, four single or two double lanes
// Notes:   register offsets are byte addresses on the ahb-lite bus
package sfx_pkg;

  // operation select, one-hot
  typedef enum logic [4:0] {
    SFX_OP_ADD = 5'h01,
    SFX_OP_SUB = 5'h02,
    SFX_OP_MUL = 5'h04,
    SFX_OP_DIV = 5'h08,
    SFX_OP_CVT = 5'h10
  } sfx_op_t;

  // exception flag bit positions
  localparam int SFX_NFLG  = 6;
  localparam int SFX_F_INV = 0;
  localparam int SFX_F_DEN = 1;
  localparam int SFX_F_DVZ = 2;
  localparam int SFX_F_OVF = 3;
  localparam int SFX_F_UNF = 4;
  localparam int SFX_F_INX = 5;

  // default results and quieting masks
  localparam logic [31:0] SFX_QNAN_IND_SP = 32'hFFC0_0000;
  localparam logic [63:0] SFX_QNAN_IND_DP = 64'hFFF8_0000_0000_0000;
  localparam logic [31:0] SFX_INT_IND_SP  = 32'h8000_0000;
  localparam logic [63:0] SFX_INT_IND_DP  = 64'h8000_0000_0000_0000;
  localparam logic [31:0] SFX_QUIET_SP    = 32'h0040_0000;
  localparam logic [63:0] SFX_QUIET_DP    = 64'h0008_0000_0000_0000;
  localparam logic [7:0]  SFX_XM_VEC      = 8'h13;

  // register byte offsets
  localparam logic [31:0] SFX_OFS_CSR  = 32'h0000_0000;
  localparam logic [31:0] SFX_OFS_IST  = 32'h0000_0004;
  localparam logic [31:0] SFX_OFS_IMSK = 32'h0000_0008;
  localparam logic [31:0] SFX_OFS_INFO = 32'h0000_000C;

  // field positions and reset values
  localparam int          SFX_CSR_FLG_LSB  = 0;
  localparam int          SFX_CSR_MSK_LSB  = 7;
  localparam logic [5:0]  SFX_MSK_RST      = 6'h3F;
  localparam int          SFX_IST_UNM      = 0;
  localparam int          SFX_IST_MSK      = 1;
  localparam int          SFX_INFO_CNT_LSB = 8;
  localparam int          SFX_INFO_VEC_LSB = 16;

endpackage

// [shared/sfx_lane_if.sv]
// Purpose: signals between the core logic and one element lane
// Assumes: W is 32 or 64
// Notes:   the core drives operands, the lane answers combinationally
`timescale 1ns/1ps
interface sfx_lane_if #(parameter int W = 32);
  import sfx_pkg::*;
  sfx_op_t              op;
  logic [W-1:0]         a;
  logic [W-1:0]         b;
  logic [W-1:0]         raw;
  logic                 ovf;
  logic                 unf;
  logic                 inx;
  logic                 cvt_inv;
  logic [W-1:0]         res;
  logic [SFX_NFLG-1:0]  raised;

  modport core (output op, a, b, raw, ovf, unf, inx, cvt_inv,
                input  res, raised);
  modport lane (input  op, a, b, raw, ovf, unf, inx, cvt_inv,
                output res, raised);
endinterface // sfx_lane_if

// [rtl/sfx_lane.sv]
// Purpose: nan selection and exception detection for one element
// Assumes: raw result and post flags come from the arithmetic unit
// Notes:   purely combinational, one instance per lane
`timescale 1ns/1ps
module sfx_lane #(parameter int W = 32) (
  // lane signals
  sfx_lane_if.lane lp
);
  import sfx_pkg::*;

  localparam int EW = (W == 32) ? 8 : 11;
  localparam int FW = W - EW - 1;
  localparam logic [W-1:0] QM  = (W == 32) ? W'(SFX_QUIET_SP)
                                           : W'(SFX_QUIET_DP);
  localparam logic [W-1:0] QI  = (W == 32) ? W'(SFX_QNAN_IND_SP)
                                           : W'(SFX_QNAN_IND_DP);
  localparam logic [W-1:0] II  = (W == 32) ? W'(SFX_INT_IND_SP)
                                           : W'(SFX_INT_IND_DP);

  // class bits: nan, snan, inf, zero, denormal
  function automatic logic [4:0] fclass(input logic [W-1:0] v);
    logic ones;
    logic zer;
    logic fnz;
    ones = &v[W-2 -: EW];
    zer  = ~|v[W-2 -: EW];
    fnz  = |v[FW-1:0];
    return {ones & fnz, ones & fnz & ~v[FW-1], ones & ~fnz,
            zer & ~fnz, zer & fnz};
  endfunction

  logic [4:0]          ca;
  logic [4:0]          cb;
  logic                b_neg;
  logic                inv_ar;
  logic                two;
  logic                any_nan;
  logic [W-1:0]        res_v;
  logic [SFX_NFLG-1:0] rz_v;

  assign ca = fclass(lp.a);
  assign cb = fclass(lp.b);

  // per-element selection, no other lane involved
  always_comb begin
    two     = (lp.op != SFX_OP_CVT);
    b_neg   = lp.b[W-1] ^ (lp.op == SFX_OP_SUB);
    any_nan = ca[4] | (two & cb[4]);
    case (lp.op)
      SFX_OP_ADD, SFX_OP_SUB: inv_ar = ca[2] & cb[2] & (lp.a[W-1] != b_neg);
      SFX_OP_MUL: inv_ar = (ca[2] & cb[1]) | (ca[1] & cb[2]);
      SFX_OP_DIV: inv_ar = (ca[2] & cb[2]) | (ca[1] & cb[1]);
      SFX_OP_CVT: inv_ar = lp.cvt_inv;
      default:    inv_ar = 1'b0;
    endcase
    rz_v  = '0;
    res_v = lp.raw;
    if (lp.op == SFX_OP_CVT && (ca[4] | lp.cvt_inv)) begin
      // conversion of nan or out of range gives integer indefinite
      rz_v[SFX_F_INV] = 1'b1;
      res_v = II;
    end else if (any_nan) begin
      // first nan wins, quieted; other flags suppressed
      rz_v[SFX_F_INV] = ca[3] | (two & cb[3]);
      res_v = ca[4] ? (lp.a | QM) : (lp.b | QM);
    end else if (inv_ar) begin
      rz_v[SFX_F_INV] = 1'b1;
      res_v = QI;
    end else if (lp.op == SFX_OP_DIV && cb[1]) begin
      rz_v[SFX_F_DVZ] = 1'b1;
    end else begin
      // denormal on operands, traps on the computed result
      rz_v[SFX_F_DEN] = ca[0] | (two & cb[0]);
      rz_v[SFX_F_OVF] = lp.ovf;
      rz_v[SFX_F_UNF] = lp.unf;
      rz_v[SFX_F_INX] = lp.inx;
    end
  end

  assign lp.res    = res_v;
  assign lp.raised = rz_v;

endmodule // sfx_lane

// [rtl/sfx_exc_top.sv]
// Purpose: simd fp exception detection and result selection
// Assumes: issue path pairs lane operands; arithmetic unit answers
//          in the issue cycle with raw result and trap flags
// Notes:   one result cycle after issue; ahb-lite slave, zero wait
`timescale 1ns/1ps
module sfx_exc_top (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // issue path
  input  wire logic                   iss_valid,
  input  wire sfx_pkg::sfx_op_t       iss_op,
  input  wire logic                   iss_dbl,
  input  wire logic                   iss_packed,
  input  wire logic [127:0]           iss_src1,
  input  wire logic [127:0]           iss_src2,
  // arithmetic unit, same cycle as issue
  input  wire logic [127:0]           ar_result,
  input  wire logic [3:0]             ar_ovf,
  input  wire logic [3:0]             ar_unf,
  input  wire logic [3:0]             ar_inx,
  input  wire logic [3:0]             ar_cvt_inv,
  // retirement and exception delivery
  output logic                        res_valid,
  output logic                        res_wr,
  output logic [127:0]                res_data,
  output logic                        exc_req,
  output logic [7:0]                  exc_vector,
  output logic [5:0]                  exc_flags,
  // interrupt
  output logic                        irq
);
  import sfx_pkg::*;

  typedef struct packed {
    logic [SFX_NFLG-1:0] flags;
    logic [SFX_NFLG-1:0] masks;
    logic [1:0]          ist;
    logic [1:0]          imsk;
    logic [SFX_NFLG-1:0] last_flags;
    logic [7:0]          exc_cnt;
    logic                ab_act;
    logic                ab_wr;
    logic [31:0]         ab_addr;
    logic [31:0]         rdata;
    logic                rv;
    logic                rw;
    logic [127:0]        rdat;
    logic                xq;
    logic [SFX_NFLG-1:0] xf;
  } sfx_state_t;

  sfx_state_t          s_r;
  sfx_state_t          s_nxt;

  logic [31:0]         sp_res [4];
  logic [SFX_NFLG-1:0] sp_rz  [4];
  logic [63:0]         dp_res [2];
  logic [SFX_NFLG-1:0] dp_rz  [2];
  logic [3:0]          sp_act;
  logic [1:0]          dp_act;
  logic [SFX_NFLG-1:0] raised_all;
  logic [SFX_NFLG-1:0] unm;
  logic                unm_any;
  logic [127:0]        merged;

  // single precision lanes
  for (genvar g = 0; g < 4; g++) begin : g_sp
    sfx_lane_if #(.W(32)) sp_if ();
    assign sp_if.op      = iss_op;
    assign sp_if.a       = iss_src1[32*g +: 32];
    assign sp_if.b       = iss_src2[32*g +: 32];
    assign sp_if.raw     = ar_result[32*g +: 32];
    assign sp_if.ovf     = ar_ovf[g];
    assign sp_if.unf     = ar_unf[g];
    assign sp_if.inx     = ar_inx[g];
    assign sp_if.cvt_inv = ar_cvt_inv[g];
    assign sp_res[g]     = sp_if.res;
    assign sp_rz[g]      = sp_if.raised;
    sfx_lane #(.W(32)) u_lane (
      .lp (sp_if)
    );
  end

  // double precision lanes
  for (genvar g = 0; g < 2; g++) begin : g_dp
    sfx_lane_if #(.W(64)) dp_if ();
    assign dp_if.op      = iss_op;
    assign dp_if.a       = iss_src1[64*g +: 64];
    assign dp_if.b       = iss_src2[64*g +: 64];
    assign dp_if.raw     = ar_result[64*g +: 64];
    assign dp_if.ovf     = ar_ovf[g];
    assign dp_if.unf     = ar_unf[g];
    assign dp_if.inx     = ar_inx[g];
    assign dp_if.cvt_inv = ar_cvt_inv[g];
    assign dp_res[g]     = dp_if.res;
    assign dp_rz[g]      = dp_if.raised;
    sfx_lane #(.W(64)) u_lane (
      .lp (dp_if)
    );
  end

  // active lanes: scalar uses the lowest element only
  assign sp_act = (!iss_dbl && iss_packed) ? 4'hF : {3'h0, !iss_dbl};
  assign dp_act = ( iss_dbl && iss_packed) ? 2'h3 : {1'b0, iss_dbl};

  // combine lane flags and results; inactive elements keep src1
  always_comb begin
    raised_all = '0;
    merged     = iss_src1;
    for (int i = 0; i < 4; i++) begin
      if (sp_act[i]) begin
        raised_all = raised_all | sp_rz[i];
        merged[32*i +: 32] = sp_res[i];
      end
    end
    for (int j = 0; j < 2; j++) begin
      if (dp_act[j]) begin
        raised_all = raised_all | dp_rz[j];
        merged[64*j +: 64] = dp_res[j];
      end
    end
  end

  // a zero mask bit lets the exception through
  assign unm     = raised_all & ~s_r.masks;
  assign unm_any = |unm;

  // next state: bus write, issue, then bus address phase
  always_comb begin
    s_nxt    = s_r;
    s_nxt.rv = 1'b0;
    s_nxt.xq = 1'b0;
    // data phase write from the previous address phase
    if (s_r.ab_act && s_r.ab_wr) begin
      case (s_r.ab_addr)
        SFX_OFS_CSR: begin
          s_nxt.flags = hwdata[SFX_CSR_FLG_LSB +: SFX_NFLG];
          s_nxt.masks = hwdata[SFX_CSR_MSK_LSB +: SFX_NFLG];
        end
        SFX_OFS_IST:  s_nxt.ist  = s_r.ist & ~hwdata[1:0];
        SFX_OFS_IMSK: s_nxt.imsk = hwdata[1:0];
        default:      s_nxt.ist  = s_nxt.ist;
      endcase
    end
    // issue; hardware sets win over a software clear
    if (iss_valid) begin
      s_nxt.rv    = 1'b1;
      s_nxt.flags = s_nxt.flags | raised_all;
      s_nxt.xf    = raised_all;
      if (unm_any) begin
        // no result at all, destination keeps its sources
        s_nxt.rw   = 1'b0;
        s_nxt.rdat = '0;
        s_nxt.xq   = 1'b1;
        s_nxt.last_flags = raised_all;
        s_nxt.exc_cnt    = s_r.exc_cnt + 8'h01;
        s_nxt.ist[SFX_IST_UNM] = 1'b1;
      end else begin
        // masked or clean: write the selected default or raw result
        s_nxt.rw   = 1'b1;
        s_nxt.rdat = merged;
        if (|raised_all) begin
          s_nxt.ist[SFX_IST_MSK] = 1'b1;
        end
      end
    end
    // address phase capture and read data
    s_nxt.ab_act  = hsel && hready && htrans[1];
    s_nxt.ab_wr   = hwrite;
    s_nxt.ab_addr = haddr;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr)
        SFX_OFS_CSR: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[SFX_CSR_FLG_LSB +: SFX_NFLG] = s_nxt.flags;
          s_nxt.rdata[SFX_CSR_MSK_LSB +: SFX_NFLG] = s_nxt.masks;
        end
        SFX_OFS_IST:  s_nxt.rdata = {30'h0, s_nxt.ist};
        SFX_OFS_IMSK: s_nxt.rdata = {30'h0, s_nxt.imsk};
        SFX_OFS_INFO: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[SFX_NFLG-1:0] = s_nxt.last_flags;
          s_nxt.rdata[SFX_INFO_CNT_LSB +: 8] = s_nxt.exc_cnt;
          s_nxt.rdata[SFX_INFO_VEC_LSB +: 8] = SFX_XM_VEC;
        end
        default:      s_nxt.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r       <= '0;
      s_r.masks <= SFX_MSK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = s_r.rdata;
  assign res_valid  = s_r.rv;
  assign res_wr     = s_r.rw && s_r.rv;
  assign res_data   = s_r.rdat;
  assign exc_req    = s_r.xq;
  assign exc_vector = SFX_XM_VEC;
  assign exc_flags  = s_r.xf;
  assign irq        = |(s_r.ist & s_r.imsk);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_unmasked_nowrite:
    assert property (iss_valid && unm_any
                     |=> res_valid && !res_wr && exc_req)
    else $error("unmasked exception wrote a result");

  chk_no_result_data:
    assert property (iss_valid && unm_any |=> res_data == 128'h0)
    else $error("unmasked exception left result data");

  chk_masked_write:
    assert property (iss_valid && !unm_any
                     |=> res_wr && !exc_req && res_data == $past(merged))
    else $error("masked or clean op did not write its result");

  chk_flag_sticky:
    assert property (iss_valid |=> (s_r.flags & $past(raised_all))
                                   == $past(raised_all))
    else $error("raised flag not recorded");

  chk_packed_or:
    assert property (iss_valid && !iss_dbl && iss_packed |=>
                     exc_flags == ($past(sp_rz[0]) | $past(sp_rz[1])
                                   | $past(sp_rz[2]) | $past(sp_rz[3])))
    else $error("packed flags differ from or of lanes");

  chk_exc_vector:
    assert property (exc_req |-> exc_vector == 8'h13 && !res_wr
                     && exc_flags != 6'h00)
    else $error("exception delivered without vector or flags");

  chk_snan_quiet:
    assert property (iss_valid && !iss_dbl && iss_op == SFX_OP_ADD
                     && &iss_src1[30:23] && !iss_src1[22]
                     && |iss_src1[21:0] |->
                     sp_res[0] == (iss_src1[31:0] | 32'h0040_0000)
                     && sp_rz[0][SFX_F_INV])
    else $error("signalling nan not quieted or not invalid");

  chk_qnan_first:
    assert property (iss_valid && !iss_dbl && iss_op == SFX_OP_MUL
                     && &iss_src1[30:22] |->
                     sp_res[0] == iss_src1[31:0]
                     && sp_rz[0][SFX_NFLG-1:1] == 5'h00)
    else $error("quiet first nan not propagated cleanly");

  chk_indef:
    assert property (iss_valid && !iss_dbl && iss_op == SFX_OP_SUB
                     && iss_src1[63:32] == 32'h7F80_0000
                     && iss_src2[63:32] == 32'h7F80_0000 |->
                     sp_res[1] == 32'hFFC0_0000 && sp_rz[1] == 6'h01)
    else $error("inf minus inf did not give indefinite");

  chk_cvt_indef:
    assert property (iss_valid && !iss_dbl && iss_op == SFX_OP_CVT
                     && &iss_src1[30:23] && |iss_src1[22:0] |->
                     sp_res[0] == 32'h8000_0000)
    else $error("nan conversion did not give integer indefinite");

  chk_exc_pulse:
    assert property (exc_req |-> $past(iss_valid) && $past(unm_any))
    else $error("exception request without an unmasked issue");

  chk_result_pulse:
    assert property (res_valid |-> $past(iss_valid))
    else $error("result pulse without an issue");

  chk_exc_count:
    assert property (iss_valid && unm_any
                     |=> s_r.exc_cnt == $past(s_r.exc_cnt) + 8'h01)
    else $error("delivered exception not counted");

  chk_masked_absorb:
    assert property (iss_valid && |raised_all && !unm_any
                     |=> !exc_req && s_r.ist[SFX_IST_MSK])
    else $error("masked exception signalled or not noted");

  chk_dvz_raw:
    assert property (iss_valid && !iss_dbl && iss_op == SFX_OP_DIV
                     && iss_src2[30:0] == 31'h0
                     && !(&iss_src1[30:23]) && |iss_src1[30:0] |->
                     sp_rz[0] == 6'h04 && sp_res[0] == ar_result[31:0])
    else $error("divide by zero flag or raw result wrong");

  chk_den_lane:
    assert property (iss_valid && !iss_dbl && iss_op == SFX_OP_MUL
                     && iss_src1[94:87] == 8'h00 && |iss_src1[86:64]
                     && !(&iss_src2[94:87]) |->
                     sp_rz[2][SFX_F_DEN])
    else $error("denormal operand not reported in its lane");

endmodule // sfx_exc_top

// [test/sfx_arith_model.sv]
// Purpose: stand-in for the arithmetic unit beside the exception block
// Assumes: it answers in the issue cycle with a fixed mix of operands
// Notes:   outside an issue every output is inverted, never left stale
`timescale 1ns/1ps
module sfx_arith_model (
  // issue side
  input  wire logic         iss_valid,
  input  wire logic [127:0] iss_src1,
  input  wire logic [127:0] iss_src2,
  // trap pattern picked by the bench: cvt, inx, unf, ovf
  input  wire logic [15:0]  trap,
  // answer to the exception block
  output logic [127:0]      ar_result,
  output logic [3:0]        ar_ovf,
  output logic [3:0]        ar_unf,
  output logic [3:0]        ar_inx,
  output logic [3:0]        ar_cvt_inv
);
  logic [127:0] raw;
  // raw result and flags, scrambled when no issue stands
  always_comb begin
    raw = ~(iss_src1 ^ iss_src2);
    ar_result = iss_valid ? raw : ~raw;
    {ar_cvt_inv, ar_inx, ar_unf, ar_ovf} = iss_valid ? trap : ~trap;
  end
endmodule // sfx_arith_model

// [test/sfx_exc_top_tb.sv]
// Purpose: self-checking bench of the simd fp exception block
// Assumes: bench tracks masks and sticky flags, models single lanes
// Notes:   random operands come from an xorshift seeded with 5
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module sfx_exc_top_tb;
  import sfx_pkg::*;
  // bench state and design signals
  logic         clk, nrst, hsel, hwrite, hready, iss_valid, iss_dbl;
  logic         iss_packed, hreadyout, hresp, res_valid, res_wr;
  logic         exc_req, irq;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr, hwdata, hrdata, seed, rd;
  logic [127:0] iss_src1, iss_src2, ar_result, res_data;
  logic [3:0]   ar_ovf, ar_unf, ar_inx, ar_cvt_inv;
  logic [15:0]  trap;
  logic [7:0]   exc_vector;
  logic [5:0]   exc_flags, msk, sticky;
  sfx_op_t      iss_op;
  int           fail_count, n_checks, cyc;
  localparam logic [31:0] SPC [8] = '{32'h7F80_0000, 32'hFF80_0000,
    32'h0000_0000, 32'h8000_0000, 32'h7FC0_1234, 32'h7F80_0055,
    32'hFF81_0000, 32'h0000_0123};
  localparam sfx_op_t OPS [4] = '{SFX_OP_ADD, SFX_OP_SUB, SFX_OP_MUL,
    SFX_OP_DIV};

  // design under test and arithmetic stand-in
  assign hready = hreadyout;
  sfx_exc_top u_sfx_exc_top (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .iss_valid(iss_valid),
    .iss_op(iss_op), .iss_dbl(iss_dbl), .iss_packed(iss_packed),
    .iss_src1(iss_src1), .iss_src2(iss_src2), .ar_result(ar_result),
    .ar_ovf(ar_ovf), .ar_unf(ar_unf), .ar_inx(ar_inx),
    .ar_cvt_inv(ar_cvt_inv), .res_valid(res_valid), .res_wr(res_wr),
    .res_data(res_data), .exc_req(exc_req), .exc_vector(exc_vector),
    .exc_flags(exc_flags), .irq(irq));
  sfx_arith_model u_sfx_arith_model (.iss_valid(iss_valid),
    .iss_src1(iss_src1), .iss_src2(iss_src2), .trap(trap),
    .ar_result(ar_result), .ar_ovf(ar_ovf), .ar_unf(ar_unf),
    .ar_inx(ar_inx), .ar_cvt_inv(ar_cvt_inv));

  // 20 mhz clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // xorshift source and operand pickers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] rnorm();
    logic [31:0] v;
    v = xs();
    v[30:29] = 2'b01;
    return v;
  endfunction
  function automatic logic [31:0] rop();
    logic [31:0] v;
    v = xs();
    if (v[1:0] == 2'b00) return SPC[v[4:2]];
    return rnorm();
  endfunction

  // one single lane: {flags, result}
  function automatic logic [37:0] lane_ref(sfx_op_t op, logic [31:0] a,
      logic [31:0] b, logic [31:0] r, logic [2:0] trp);
    logic an, bn, ai, bi, az, bz, inv, den;
    an = (&a[30:23]) & (|a[22:0]);
    bn = (&b[30:23]) & (|b[22:0]);
    ai = (&a[30:23]) & ~(|a[22:0]);
    bi = (&b[30:23]) & ~(|b[22:0]);
    az = ~(|a[30:0]);
    bz = ~(|b[30:0]);
    den = (~(|a[30:23]) & ~az) | (~(|b[30:23]) & ~bz);
    if (an | bn)
      return {5'h0, (an & ~a[22]) | (bn & ~b[22]),
              an ? (a | SFX_QUIET_SP) : (b | SFX_QUIET_SP)};
    case (op)
      SFX_OP_ADD: inv = ai & bi & (a[31] ^ b[31]);
      SFX_OP_SUB: inv = ai & bi & ~(a[31] ^ b[31]);
      SFX_OP_MUL: inv = (ai & bz) | (az & bi);
      default:    inv = (ai & bi) | (az & bz);
    endcase
    if (inv) return {6'h01, SFX_QNAN_IND_SP};
    if (op == SFX_OP_DIV && bz) return {6'h04, r};
    return {trp, 1'b0, den, 1'b0, r};
  endfunction

  // ahb-lite single word transfer, waits on hready
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'b10, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hready_resp", 2'b10, {hreadyout, hresp})
    // let the write land before anything looks at the outputs
    #1;
  endtask
  task automatic rdchk(logic [31:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("register", e, rd)
  endtask

  // one issue, outputs looked at in the answer cycle
  task automatic issue(sfx_op_t op, logic dbl, logic pk,
      logic [127:0] s1, logic [127:0] s2, logic [15:0] t);
    @(posedge clk);
    {iss_valid, iss_op, iss_dbl, iss_packed} <= {1'b1, op, dbl, pk};
    {iss_src1, iss_src2, trap} <= {s1, s2, t};
    @(posedge clk);
    iss_valid <= 1'b0;
    #1;
  endtask
  task automatic expect_res(logic [127:0] d, logic [5:0] f);
    logic unm;
    unm = |(f & ~msk);
    `CHK("res_valid", 1'b1, res_valid)
    `CHK("res_wr", ~unm, res_wr)
    `CHK("res_data", unm ? 128'h0 : d, res_data)
    `CHK("exc_req", unm, exc_req)
    `CHK("exc_flags", f, exc_flags)
    `CHK("exc_vector", SFX_XM_VEC, exc_vector)
    sticky |= f;
  endtask
  task automatic run_sp(sfx_op_t op, logic pk, logic [127:0] s1,
      logic [127:0] s2, logic [15:0] t);
    logic [127:0] d, r;
    logic [5:0]   f;
    logic [37:0]  l;
    r = ~(s1 ^ s2);
    d = s1;
    f = 6'h0;
    for (int k = 0; k < (pk ? 4 : 1); k++) begin
      l = lane_ref(op, s1[32*k+:32], s2[32*k+:32], r[32*k+:32],
                   {t[8+k], t[4+k], t[k]});
      d[32*k+:32] = l[31:0];
      f |= l[37:32];
    end
    issue(op, 1'b0, pk, s1, s2, t);
    expect_res(d, f);
  endtask

  // main sequence
  initial begin
    sfx_op_t      op;
    logic [127:0] a, b;
    logic [15:0]  t;
    {clk, nrst, hsel, hwrite, iss_valid, iss_dbl, iss_packed} = '0;
    {htrans, hsize, haddr, hwdata, iss_src1, iss_src2, trap} = '0;
    iss_op = SFX_OP_ADD;
    {fail_count, n_checks} = '0;
    seed = 32'h0000_0005;
    msk = 6'h3F;
    sticky = 6'h0;
    hsize = 3'h2;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    `CHK("irq", 1'b0, irq)
    rdchk(SFX_OFS_CSR, 32'h0000_1F80);
    rdchk(SFX_OFS_INFO, 32'h0013_0000);
    rdchk(32'h0000_0010, 32'h0);
    // masked nan, invalid and trap cases
    run_sp(SFX_OP_ADD, 1'b0, {96'h1, 32'h7F80_0055}, 128'h3F80_0000, 16'h0);
    rdchk(SFX_OFS_CSR, 32'h0000_1F81);
    run_sp(SFX_OP_SUB, 1'b1, {32'h7FC0_0003, 32'h7FC0_0002, 32'h7F80_0000,
      32'hFF81_0000}, {32'h7F80_0011, 32'h7FC0_0009, 32'h7F80_0000,
      32'h3F80_0000}, 16'h0F0F);
    run_sp(SFX_OP_MUL, 1'b1, {32'h3F80_0000, 32'h0000_0123, 32'h4000_0000,
      32'h3F80_0000}, {4{32'h4000_0000}}, 16'h0402);
    run_sp(SFX_OP_DIV, 1'b0, 128'h4000_0000, 128'h0, 16'h0);
    issue(SFX_OP_MUL, 1'b1, 1'b1, {64'h7FF0_0000_0000_0001,
      64'h7FF0_0000_0000_0000}, {64'h3FF0_0000_0000_0000, 64'h0}, 16'h0);
    expect_res({64'h7FF0_0000_0000_0001 | SFX_QUIET_DP,
      SFX_QNAN_IND_DP}, 6'h01);
    a = {96'h1_0000_0002_0000_0003, 32'h7FC0_0000};
    issue(SFX_OP_CVT, 1'b0, 1'b0, a, 128'h0, 16'h0);
    expect_res({a[127:32], SFX_INT_IND_SP}, 6'h01);
    issue(SFX_OP_CVT, 1'b0, 1'b0, 128'h3F80_0000, 128'h0, 16'h1000);
    expect_res({96'h0, SFX_INT_IND_SP}, 6'h01);
    rdchk(SFX_OFS_CSR, {19'h0, msk, 1'b0, sticky});
    // interrupt raise, clear, mask; unmasked delivery
    bus(1'b1, SFX_OFS_IMSK, 32'h3);
    `CHK("irq", 1'b1, irq)
    rdchk(SFX_OFS_IST, 32'h2);
    bus(1'b1, SFX_OFS_IST, 32'h2);
    rdchk(SFX_OFS_IST, 32'h0);
    `CHK("irq", 1'b0, irq)
    msk = 6'h0;
    sticky = 6'h0;
    bus(1'b1, SFX_OFS_CSR, 32'h0);
    run_sp(SFX_OP_MUL, 1'b1, {4{32'h7FC0_0007}}, {4{32'hFFC0_0001}}, 16'h0);
    run_sp(SFX_OP_ADD, 1'b1, {32'h3F80_0000, 32'h7F80_0055,
      64'h3F80_0000_4000_0000}, {4{32'h3F80_0000}}, 16'h0);
    `CHK("irq", 1'b1, irq)
    rdchk(SFX_OFS_IST, 32'h1);
    rdchk(SFX_OFS_INFO, 32'h0013_0101);
    bus(1'b1, SFX_OFS_IMSK, 32'h0);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, SFX_OFS_IST, 32'h3);
    bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    rdchk(SFX_OFS_CSR, {26'h0, sticky});
    // random operands, masks and traps
    for (int i = 0; i < 80; i++) begin
      if (i % 10 == 0) begin
        rd = xs();
        msk = rd[5:0];
        sticky = 6'h0;
        bus(1'b1, SFX_OFS_CSR, {19'h0, msk, 7'h0});
      end
      op = OPS[xs() % 4];
      for (int k = 0; k < 4; k++) begin
        a[32*k+:32] = rop();
        b[32*k+:32] = rop();
        if (op == SFX_OP_DIV && b[32*k+:31] == 31'h0)
          a[32*k+:32] = rnorm();
      end
      rd = xs() & xs();
      t = {4'h0, rd[11:0]};
      run_sp(op, seed[3], a, b, t);
    end
    rdchk(SFX_OFS_CSR, {19'h0, msk, 1'b0, sticky});
    summarize();
  end
endmodule // sfx_exc_top_tb
